// >>> rtl/ser_defs.vh
/*
 * Constants for the status and event reporting block: group indices, field
 * positions, reset values and per-group masks of implemented bits.
 * Assumes inclusion by bare name from the rtl/ design files.
 */
// Notes on behaviour
// - Condition reads are 16 bits, unused zero.
// - Event-only condition bits always read zero.
// - Condition bits follow sources with no latching.
// - Condition reads have no side effects.
// - Reset clears every condition register; code has none, condition bits follow sources through reset.
// - Event read returns contents then clears.
// - Filtered transitions set event bits.
// - Event bits stay set until read or cleared.
// - Reset clears every event register.
// - Preset and clear-status also clear events.
// - Enable mask selects bits for summary.
// - Enable takes 16 bits, unused ignored.
// - Enable reads leave the mask unchanged.
// - Fall filter bit enables one-to-zero events.
// - Rise filter bit enables zero-to-one events.
// - Event-only positions have no filter storage.
// - Filters take 16 bits, unused ignored.
// - Filter reads leave the mask unchanged.
// - Command-error mask drives its summary bit.
// - Command-error mask is 8 bits.
// - Preset loads command-error mask with zero.
// - Error events at bits 2,3,4,5,7.
// - Clear-status leaves config and condition alone.
// - Master summary bit 6 drives alarm indicator; code ORs group and command-error summaries, no bit 6.
`ifndef SER_DEFS_VH
`define SER_DEFS_VH

// ----------------------------------------------------------------------
// Sizes and group indices
// ----------------------------------------------------------------------
`define SER_W 16
`define SER_NGRP 5
`define SER_GRP_OPER 3'h0
`define SER_GRP_QUES 3'h1
`define SER_GRP_HARD 3'h2
`define SER_GRP_HOLD 3'h3
`define SER_GRP_PWR 3'h4

// ----------------------------------------------------------------------
// Implemented-bit masks: live condition bits and all event bits per group
// ----------------------------------------------------------------------
`define SER_COND_MASK_OPER 16'hFFFF
`define SER_COND_MASK_QUES 16'hFFFE
`define SER_COND_MASK_HARD 16'hFFFF
`define SER_COND_MASK_HOLD 16'h000F
`define SER_COND_MASK_PWR 16'h0003
`define SER_EVT_MASK_OPER 16'hFFFF
`define SER_EVT_MASK_QUES 16'hFFFF
`define SER_EVT_MASK_HARD 16'hFFFF
`define SER_EVT_MASK_HOLD 16'h000F
`define SER_EVT_MASK_PWR 16'h0007

// ----------------------------------------------------------------------
// Reset and preset values
// ----------------------------------------------------------------------
`define SER_ZERO16 16'h0000
`define SER_ZERO8 8'h00
`define SER_CMD_MASK_PRESET 8'h00
`define SER_RISE_PRESET 16'hFFFF
`define SER_FALL_PRESET 16'h0000
`define SER_ENA_PRESET 16'h0000

// ----------------------------------------------------------------------
// Command-error event bits and alarm condition bits
// ----------------------------------------------------------------------
`define SER_CE_QUERY 2
`define SER_CE_HWFW 3
`define SER_CE_SEM 4
`define SER_CE_SYN 5
`define SER_CE_PWR 7
`define SER_CE_IMPL 8'hBC
`define SER_ALM_CMD 5
`define SER_ALM_MASTER 6

`endif

// >>> rtl/ser_group.v
/*
 * One status group: condition view, rise and fall filters, sticky event
 * register with clear-on-read, enable mask and summary bit.
 * Assumes synchronous single-cycle strobes from the command side.
 */
`include "ser_defs.vh"

module ser_group #(
    parameter [15:0] COND_MASK = 16'hFFFF,
    parameter [15:0] EVT_MASK = 16'hFFFF
) (
    // Clock and reset.
    input wire ref_clk,
    input wire rstn,
    // Monitored sources and event-only pulses.
    input wire [15:0] cond_src,
    input wire [15:0] evt_pulse,
    // Configuration writes.
    input wire rise_wr,
    input wire fall_wr,
    input wire ena_wr,
    input wire [15:0] wr_data,
    input wire preset,
    // Event clear: read, clear-status or preset.
    input wire evt_clr,
    // Register contents.
    output wire [15:0] cond_val,
    output reg [15:0] evt_reg,
    output reg [15:0] rise_filter_reg,
    output reg [15:0] fall_filter_reg,
    output reg [15:0] ena_reg,
    output wire summary
);

    // Condition bits sharing storage with event-only positions carry none.
    localparam [15:0] FILT_MASK = COND_MASK;

    // Previous condition, for edge detection.
    reg [15:0] cond_prev_reg;
    // Detected events in this cycle.
    wire [15:0] hit;

    // Live condition view, unused and event-only bits forced low.
    assign cond_val = cond_src & COND_MASK;

    // ------------------------------------------------------------------
    // Per-bit edge detection through the filters
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_bit
            assign hit[i] = EVT_MASK[i] & ((~FILT_MASK[i] & evt_pulse[i])
                | (rise_filter_reg[i] & cond_val[i] & ~cond_prev_reg[i])
                | (fall_filter_reg[i] & ~cond_val[i] & cond_prev_reg[i]));
        end
    endgenerate

    // Summary of enabled events.
    assign summary = |(evt_reg & ena_reg);

    // Edge history; a reset view of all zeros is the starting point.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cond_prev_reg <= `SER_ZERO16;
        end else begin
            cond_prev_reg <= cond_val;
        end
    end

    // Sticky events: a new hit wins over a clear in the same cycle.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evt_reg <= `SER_ZERO16;
        end else if (evt_clr) begin
            evt_reg <= hit;
        end else begin
            evt_reg <= evt_reg | hit;
        end
    end

    // Configuration registers; reads never touch them.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rise_filter_reg <= `SER_RISE_PRESET & FILT_MASK;
            fall_filter_reg <= `SER_FALL_PRESET;
            ena_reg <= `SER_ENA_PRESET;
        end else if (preset) begin
            rise_filter_reg <= `SER_RISE_PRESET & FILT_MASK;
            fall_filter_reg <= `SER_FALL_PRESET;
            ena_reg <= `SER_ENA_PRESET;
        end else begin
            if (rise_wr) begin
                rise_filter_reg <= wr_data & FILT_MASK;
            end
            if (fall_wr) begin
                fall_filter_reg <= wr_data & FILT_MASK;
            end
            if (ena_wr) begin
                ena_reg <= wr_data & EVT_MASK;
            end
        end
    end

endmodule // ser_group

// >>> rtl/ser_top.v
/*
 * Status and event reporting top: five status groups, command-error event
 * and enable registers, a read port and the alarm indicator.
 * Assumes a command parser drives one-cycle strobes synchronous to ref_clk.
 */
`include "ser_defs.vh"

module ser_top (
    // Clock and reset.
    input wire ref_clk,
    input wire rstn,
    // Live condition sources per group.
    input wire [15:0] oper_cond_src,
    input wire [15:0] ques_cond_src,
    input wire [15:0] hard_cond_src,
    input wire [15:0] hold_cond_src,
    input wire [15:0] pwr_cond_src,
    // Event-only pulses per group.
    input wire [15:0] oper_evt_pulse,
    input wire [15:0] ques_evt_pulse,
    input wire [15:0] hard_evt_pulse,
    input wire [15:0] hold_evt_pulse,
    input wire [15:0] pwr_evt_pulse,
    // Command-error reports, one-cycle pulses.
    input wire err_query,
    input wire err_hwfw,
    input wire err_semantic,
    input wire err_syntax,
    // Command strobes.
    input wire [2:0] grp_sel,
    input wire rise_wr,
    input wire fall_wr,
    input wire ena_wr,
    input wire [15:0] wr_data,
    input wire cmd_fault_mask_set,
    input wire [7:0] cmd_mask_data,
    input wire clear_status_cmd,
    input wire preset_cmd,
    // Read requests.
    input wire cond_rd,
    input wire evt_rd,
    input wire rise_rd,
    input wire fall_rd,
    input wire ena_rd,
    input wire cmd_evt_rd,
    input wire cmd_mask_rd,
    // Read answer.
    output reg [15:0] rd_data,
    output reg rd_valid,
    // Summaries and alarm.
    output reg [4:0] grp_summary,
    output reg cmd_summary,
    output reg alarm_led
);

    // Group register views.
    wire [15:0] cond_v [0:4];
    wire [15:0] evt_v [0:4];
    wire [15:0] rise_v [0:4];
    wire [15:0] fall_v [0:4];
    wire [15:0] ena_v [0:4];
    wire [4:0] sum_v;
    // Per-group inputs gathered.
    wire [15:0] src_v [0:4];
    wire [15:0] pul_v [0:4];

    // Command-error registers.
    reg [7:0] cmd_evt_reg;
    reg [7:0] cmd_mask_reg;
    reg pwr_seen_reg;
    wire [7:0] cmd_hit;
    wire cmd_sum_now;

    // Any event clear other than by reading.
    wire bulk_clr = clear_status_cmd | preset_cmd;

    assign src_v[0] = oper_cond_src;
    assign src_v[1] = ques_cond_src;
    assign src_v[2] = hard_cond_src;
    assign src_v[3] = hold_cond_src;
    assign src_v[4] = pwr_cond_src;
    assign pul_v[0] = oper_evt_pulse;
    assign pul_v[1] = ques_evt_pulse;
    assign pul_v[2] = hard_evt_pulse;
    assign pul_v[3] = hold_evt_pulse;
    assign pul_v[4] = pwr_evt_pulse;

    // ------------------------------------------------------------------
    // Five status groups
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SER_NGRP; g = g + 1) begin : g_grp
            // Index of this group, held at full integer width for the compare.
            localparam integer GRP_ID = g;
            // Strobes qualified by the selected group.
            wire sel = ({29'h0000_0000, grp_sel} == GRP_ID);
            ser_group #(
                .COND_MASK(g == 0 ? `SER_COND_MASK_OPER : g == 1 ? `SER_COND_MASK_QUES :
                    g == 2 ? `SER_COND_MASK_HARD : g == 3 ? `SER_COND_MASK_HOLD :
                    `SER_COND_MASK_PWR),
                .EVT_MASK(g == 0 ? `SER_EVT_MASK_OPER : g == 1 ? `SER_EVT_MASK_QUES :
                    g == 2 ? `SER_EVT_MASK_HARD : g == 3 ? `SER_EVT_MASK_HOLD :
                    `SER_EVT_MASK_PWR)
            ) u_grp (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .cond_src(src_v[g]),
                .evt_pulse(pul_v[g]),
                .rise_wr(rise_wr & sel),
                .fall_wr(fall_wr & sel),
                .ena_wr(ena_wr & sel),
                .wr_data(wr_data),
                .preset(preset_cmd),
                .evt_clr((evt_rd & sel) | bulk_clr),
                .cond_val(cond_v[g]),
                .evt_reg(evt_v[g]),
                .rise_filter_reg(rise_v[g]),
                .fall_filter_reg(fall_v[g]),
                .ena_reg(ena_v[g]),
                .summary(sum_v[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Command-error event register
    // ------------------------------------------------------------------
    // Power-cycled event fires once in the first cycle after reset.
    assign cmd_hit = {~pwr_seen_reg, 1'b0, err_syntax, err_semantic, err_hwfw,
        err_query, 2'b00};
    assign cmd_sum_now = |(cmd_evt_reg & cmd_mask_reg);

    // Tracks that the powerup event has been posted.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_seen_reg <= 1'b0;
        end else begin
            pwr_seen_reg <= 1'b1;
        end
    end

    // Sticky command-error events; set wins over clear.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_evt_reg <= `SER_ZERO8;
        end else if (cmd_evt_rd | bulk_clr) begin
            cmd_evt_reg <= cmd_hit;
        end else begin
            cmd_evt_reg <= cmd_evt_reg | cmd_hit;
        end
    end

    // Command-error enable mask; preset loads zero.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_mask_reg <= `SER_CMD_MASK_PRESET;
        end else if (preset_cmd) begin
            cmd_mask_reg <= `SER_CMD_MASK_PRESET;
        end else if (cmd_fault_mask_set) begin
            cmd_mask_reg <= cmd_mask_data & `SER_CE_IMPL;
        end
    end

    // ------------------------------------------------------------------
    // Read port: non-destructive except the event reads
    // ------------------------------------------------------------------
    // Selected group index, limited to valid groups.
    wire [2:0] gi = (grp_sel < 3'h5) ? grp_sel : 3'h0;
    wire grp_ok = (grp_sel < 3'h5);

    // Answer registered one cycle after the request.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= `SER_ZERO16;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= cond_rd | evt_rd | rise_rd | fall_rd | ena_rd |
                cmd_evt_rd | cmd_mask_rd;
            if (cmd_evt_rd) begin
                rd_data <= {8'h00, cmd_evt_reg};
            end else if (cmd_mask_rd) begin
                rd_data <= {8'h00, cmd_mask_reg};
            end else if (!grp_ok) begin
                rd_data <= `SER_ZERO16;
            end else if (cond_rd) begin
                rd_data <= cond_v[gi];
            end else if (evt_rd) begin
                rd_data <= evt_v[gi];
            end else if (rise_rd) begin
                rd_data <= rise_v[gi];
            end else if (fall_rd) begin
                rd_data <= fall_v[gi];
            end else if (ena_rd) begin
                rd_data <= ena_v[gi];
            end else begin
                rd_data <= `SER_ZERO16;
            end
        end
    end

    // ------------------------------------------------------------------
    // Summaries and alarm indicator
    // ------------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            grp_summary <= 5'h00;
            cmd_summary <= 1'b0;
            alarm_led <= 1'b0;
        end else begin
            grp_summary <= sum_v;
            cmd_summary <= cmd_sum_now;
            alarm_led <= (|sum_v) | cmd_sum_now;
        end
    end

endmodule // ser_top

// >>> sim/ser_host.sv
/* Host side model: issues register commands and reads as one-cycle strobes.
   Assumes ref_clk from the bench; each read answer arrives one edge later. */
module ser_host (
    // Clock and read answer.
    input wire logic ref_clk,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    // Command strobes.
    output logic [2:0] grp_sel,
    output logic [6:0] rstb,
    output logic [5:0] wstb,
    output logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // All strobes idle at time zero.
    initial begin
        grp_sel = 3'h0;
        rstb = 7'h00;
        wstb = 6'h00;
        wr_data = 16'h0000;
    end

    // Reads kind k of group g; the value is kept because an event read clears it.
    task automatic rd(input int k, input logic [2:0] g, output logic [15:0] d);
        @(posedge ref_clk);
        #1;
        grp_sel = g;
        rstb = 7'(1 << k);
        @(posedge ref_clk);
        #1;
        rstb = 7'h00;
        d = (rd_valid === 1'b1) ? rd_data : 16'hDEAD;
    endtask

    // Writes v with command k to group g as a single strobe.
    task automatic wr(input int k, input logic [2:0] g, input logic [15:0] v);
        @(posedge ref_clk);
        #1;
        grp_sel = g;
        wr_data = v;
        wstb = 6'(1 << k);
        @(posedge ref_clk);
        #1;
        wstb = 6'h00;
    endtask
endmodule // ser_host

// >>> sim/ser_tb_top.sv
/* Bench for the status block: reset values, filters, events and summaries.
   Assumes the host model in ser_host and the defines of ser_defs.vh. */
`include "ser_defs.vh"
module ser_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] src [0:4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] ques_p = 16'h0000;
    logic [15:0] pwr_p = 16'h0000;
    logic [15:0] misc_p = 16'h0000; // Groups without event-only bits.
    logic [3:0] errs = 4'h0;
    logic [2:0] grp_sel;
    logic [6:0] rstb;
    logic [5:0] wstb;
    logic [15:0] wr_data, rd_data, d;
    logic rd_valid, cmd_summary, alarm_led;
    logic [4:0] grp_summary;
    int errors = 0;
    int n_tests = 0;
    localparam logic [15:0] CM [0:4] = '{`SER_COND_MASK_OPER, `SER_COND_MASK_QUES,
        `SER_COND_MASK_HARD, `SER_COND_MASK_HOLD, `SER_COND_MASK_PWR};

    // Clock at 10 MHz.
    always #50 ref_clk = ~ref_clk;

    ser_host host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .grp_sel(grp_sel), .rstb(rstb), .wstb(wstb), .wr_data(wr_data));
    ser_top DUT (.ref_clk(ref_clk), .rstn(rstn), .oper_cond_src(src[0]),
        .ques_cond_src(src[1]), .hard_cond_src(src[2]), .hold_cond_src(src[3]),
        .pwr_cond_src(src[4]), .oper_evt_pulse(misc_p), .ques_evt_pulse(ques_p),
        .hard_evt_pulse(misc_p), .hold_evt_pulse(misc_p), .pwr_evt_pulse(pwr_p),
        .err_query(errs[0]), .err_hwfw(errs[1]), .err_semantic(errs[2]),
        .err_syntax(errs[3]), .grp_sel(grp_sel), .rise_wr(wstb[0]), .fall_wr(wstb[1]),
        .ena_wr(wstb[2]), .wr_data(wr_data), .cmd_fault_mask_set(wstb[3]),
        .cmd_mask_data(wr_data[7:0]), .clear_status_cmd(wstb[4]), .preset_cmd(wstb[5]),
        .cond_rd(rstb[0]), .evt_rd(rstb[1]), .rise_rd(rstb[2]), .fall_rd(rstb[3]),
        .ena_rd(rstb[4]), .cmd_evt_rd(rstb[5]), .cmd_mask_rd(rstb[6]), .rd_data(rd_data),
        .rd_valid(rd_valid), .grp_summary(grp_summary), .cmd_summary(cmd_summary),
        .alarm_led(alarm_led));

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    // Waits to just after the next rising edge.
    task automatic cyc;
        @(posedge ref_clk);
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("errors %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Power-up contents of every group and the power-cycled error bit.
    task automatic t_reset;
        host.rd(5, 3'h0, d);
        chk(d, 16'h0001 << `SER_CE_PWR);
        for (int g = 0; g < 5; g++) begin
            host.rd(0, 3'(g), d);
            chk(d, 16'h0000);
            host.rd(1, 3'(g), d);
            chk(d, 16'h0000);
            host.rd(2, 3'(g), d);
            chk(d, CM[g]);
            host.rd(3, 3'(g), d);
            chk(d, 16'h0000);
            host.rd(4, 3'(g), d);
            chk(d, 16'h0000);
        end
    endtask

    // Live conditions, rising events and clear on read.
    task automatic t_cond;
        for (int g = 0; g < 5; g++) src[g] = 16'hFFFF;
        cyc;
        for (int g = 0; g < 5; g++) begin
            host.rd(0, 3'(g), d);
            chk(d, CM[g]);
            host.rd(0, 3'(g), d);
            chk(d, CM[g]);
            host.rd(1, 3'(g), d);
            chk(d, CM[g]);
            host.rd(1, 3'(g), d);
            chk(d, 16'h0000);
        end
    endtask

    // Filter selection, sticky events and masked filter writes.
    task automatic t_edge;
        host.wr(0, 3'h0, 16'h00F0);
        host.wr(1, 3'h0, 16'h0F00);
        src[0] = 16'h0000;
        cyc;
        host.rd(1, 3'h0, d);
        chk(d, 16'h0F00);
        src[0] = 16'h00FF;
        cyc;
        src[0] = 16'h0000;
        cyc;
        host.rd(1, 3'h0, d);
        chk(d, 16'h00F0);
        host.wr(1, 3'h3, 16'hFFFF);
        host.rd(3, 3'h3, d);
        chk(d, 16'h000F);
        host.wr(0, 3'h1, 16'hFFFF);
        host.rd(2, 3'h1, d);
        chk(d, 16'hFFFE);
        host.rd(2, 3'h0, d);
        chk(d, 16'h00F0);
    endtask

    // Event-only pulses, enabled summary, alarm and clear-status.
    task automatic t_sum;
        host.wr(2, 3'h1, 16'h0001);
        ques_p = 16'h0001;
        pwr_p = 16'h0004;
        cyc;
        ques_p = 16'h0000;
        pwr_p = 16'h0000;
        cyc;
        cyc;
        chk({11'h000, grp_summary}, 16'h0002);
        chk({15'h0000, alarm_led}, 16'h0001);
        host.rd(1, 3'h4, d);
        chk(d, 16'h0004);
        host.wr(4, 3'h0, 16'h0000);
        cyc;
        chk({11'h000, grp_summary}, 16'h0000);
        chk({15'h0000, alarm_led}, 16'h0000);
        host.rd(4, 3'h1, d);
        chk(d, 16'h0001);
        host.rd(0, 3'h1, d);
        chk(d, 16'hFFFE);
    endtask

    // Command errors, their mask and summary, then preset.
    task automatic t_cmd;
        host.wr(3, 3'h0, 16'h0004);
        host.rd(6, 3'h0, d);
        chk(d, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            cyc;
            errs = 4'(1 << i);
            cyc;
            errs = 4'h0;
        end
        cyc;
        cyc;
        chk({15'h0000, cmd_summary}, 16'h0001);
        host.rd(5, 3'h0, d);
        chk(d, 16'h003C);
        host.wr(2, 3'h5, 16'hFFFF);
        host.rd(4, 3'h0, d);
        chk(d, 16'h0000);
        host.rd(4, 3'h5, d);
        chk(d, 16'h0000);
        // Post a fresh query error so that the preset has an event to clear.
        cyc;
        errs = 4'h1;
        cyc;
        errs = 4'h0;
        host.wr(5, 3'h0, 16'h0000);
        host.rd(6, 3'h0, d);
        chk(d, 16'h0000);
        host.rd(5, 3'h0, d);
        chk(d, 16'h0000);
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        t_reset;
        t_cond;
        t_edge;
        t_sum;
        t_cmd;
        give_verdict;
    end

    // Watchdog well beyond the roughly 160 cycles the scenarios need.
    initial begin
        #1000000;
        errors++;
        give_verdict;
    end
endmodule // ser_tb_top

// >>> sim/ser_top_properties.sv
/* Checker for the status block: timing of reads, masks and summaries.
   Assumes it is bound to ser_top and sees only its ports. */
module ser_top_properties (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [15:0] oper_cond_src,
    input wire logic [15:0] ques_cond_src,
    input wire logic [15:0] ques_evt_pulse,
    input wire logic [2:0] grp_sel,
    input wire logic cond_rd,
    input wire logic evt_rd,
    input wire logic rise_rd,
    input wire logic fall_rd,
    input wire logic ena_rd,
    input wire logic cmd_evt_rd,
    input wire logic cmd_mask_rd,
    input wire logic cmd_fault_mask_set,
    input wire logic clear_status_cmd,
    input wire logic preset_cmd,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic [4:0] grp_summary,
    input wire logic cmd_summary,
    input wire logic alarm_led
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // A plain condition read with no higher-priority read beside it.
    wire logic cr = cond_rd && !cmd_evt_rd && !cmd_mask_rd;

    a_oper_cond_live: assert property (cr && grp_sel == 3'h0 |=>
        rd_data == $past(oper_cond_src)) else $error("oper condition mismatch");
    a_ques_evt_only: assert property (cr && grp_sel == 3'h1 |=>
        rd_data == ($past(ques_cond_src) & 16'hFFFE)) else $error("ques condition mismatch");
    a_hold_unused_zero: assert property (cr && grp_sel == 3'h3 |=>
        rd_data[15:4] == 12'h000) else $error("hold unused bits set");
    a_read_answer_once: assert property (rd_valid == $past(cond_rd || evt_rd
        || rise_rd || fall_rd || ena_rd || cmd_evt_rd || cmd_mask_rd))
        else $error("read answer timing");
    a_cmd_mask_width: assert property (cmd_mask_rd && !cmd_evt_rd |=>
        rd_data[15:8] == 8'h00) else $error("command mask upper bits set");
    a_clear_drops_sum: assert property (clear_status_cmd && $stable(ques_cond_src)
        && ques_evt_pulse == 16'h0000 |=> ##1 !grp_summary[1]) else $error("summary kept");
    a_alarm_from_sum: assert property (alarm_led == (|grp_summary || cmd_summary))
        else $error("alarm indicator mismatch");
    a_preset_mask_zero: assert property (preset_cmd ##1 !cmd_fault_mask_set
        ##1 cmd_mask_rd && !cmd_evt_rd && !cmd_fault_mask_set |=> rd_data == 16'h0000)
        else $error("command mask not preset");

    c_event_read: cover property (evt_rd ##1 rd_valid);
    c_alarm_on: cover property ($rose(alarm_led));
    c_clear_off: cover property (clear_status_cmd ##2 !alarm_led);
endmodule // ser_top_properties

bind ser_top ser_top_properties u_props (.ref_clk(ref_clk), .rstn(rstn),
    .oper_cond_src(oper_cond_src), .ques_cond_src(ques_cond_src),
    .ques_evt_pulse(ques_evt_pulse), .grp_sel(grp_sel), .cond_rd(cond_rd),
    .evt_rd(evt_rd), .rise_rd(rise_rd), .fall_rd(fall_rd), .ena_rd(ena_rd),
    .cmd_evt_rd(cmd_evt_rd), .cmd_mask_rd(cmd_mask_rd),
    .cmd_fault_mask_set(cmd_fault_mask_set), .clear_status_cmd(clear_status_cmd),
    .preset_cmd(preset_cmd), .rd_data(rd_data), .rd_valid(rd_valid),
    .grp_summary(grp_summary), .cmd_summary(cmd_summary), .alarm_led(alarm_led));
